// file: verilog/pin_mux_pkg.sv
// Constants shared by the port pin function multiplexer and its latch slice.
// Assumes a single 25 MHz system clock and an active-high reset.
package pin_mux_pkg;

  // ****************************************
  // Port widths
  // ****************************************
  localparam int LF_PORT_W = 3;
  localparam int PLAIN_PORT_W = 7;
  localparam int SER_PORT_W = 8;
  localparam int ANA_PORT_W = 8;
  localparam int SEG_GROUP_W = 8;
  localparam int SEG_GROUPS = 4;
  localparam int SEG_PORT_W = 28;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] LF_LATCH_RST = 3'h7;
  localparam logic [6:0] PLAIN_LATCH_RST = 7'h7F;
  localparam logic [7:0] SER_LATCH_RST = 8'hFF;
  localparam logic [7:0] ANA_LATCH_RST = 8'h00;
  localparam logic [27:0] SEG_LATCH_RST = 28'hFFFFFFF;

  // ****************************************
  // Bit positions on the shared ports
  // ****************************************
  localparam int IRQ5_BIT = 0;
  localparam int LF_IN_BIT = 1;
  localparam int LF_OUT_BIT = 2;
  localparam int SER2_DO_BIT = 7;
  localparam int SER2_DI_BIT = 6;
  localparam int SER2_CK_BIT = 5;
  localparam int SER1_DO_BIT = 4;
  localparam int SER1_DI_BIT = 3;
  localparam int SER1_CK_BIT = 2;
  localparam int PWM_BIT = 1;
  localparam int IRQ3_BIT = 0;

  // ****************************************
  // Timing of the driven reset pulse
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_DRIVE_NS = 640;
  localparam int RESET_DRIVE_CYCLES =
    (RESET_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W = 8;

  // States of the reset pin driver.
  typedef enum logic [1:0]
  {
    RST_IDLE = 2'b01,
    RST_DRIVE = 2'b10
  } rst_state_t;

endpackage

// file: verilog/latch_port_if.sv
// Carrier between the multiplexer top and one output latch slice.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface latch_port_if #(parameter int W = 8);
  logic wr;
  logic [W-1:0] wdata;
  logic [W-1:0] alt_sel;
  logic [W-1:0] alt_val;
  logic [W-1:0] latch;
  logic [W-1:0] drive;

  // The top steers the slice and reads back its latch and pin value.
  modport ctrl
  (
    output wr, wdata, alt_sel, alt_val,
    input latch, drive
  );
  modport port
  (
    input wr, wdata, alt_sel, alt_val,
    output latch, drive
  );
endinterface
`default_nettype wire

// file: verilog/latch_port.sv
// One port output latch with alternate output gating.
// Assumes writes come as single-cycle strobes on the system clock.
`timescale 1ns/1ps
`default_nettype none
module latch_port #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '1
)
(
  input wire logic clk_sys,
  input wire logic rst,
  latch_port_if.port lp
);

  typedef struct packed
  {
    logic [W-1:0] latch;
  } slice_t;

  slice_t state_reg;
  slice_t state_next;

  // A write strobe replaces the whole latch word.
  always_comb
  begin
    state_next = state_reg;
    if (lp.wr)
    begin
      state_next.latch = lp.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg.latch <= RESET_VAL;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Pin value: alternate output ANDed with the latch, else the latch alone.
  // Latch 0 pulls the pin low, so a latch of 1 leaves it free for input.
  assign lp.latch = state_reg.latch;
  assign lp.drive = state_reg.latch & (~lp.alt_sel | lp.alt_val);

endmodule
`default_nettype wire

// file: verilog/port_pin_function_mux.sv
// Pin sharing logic for the general ports, serial, timer, analog,
// segment and reset pins of the controller.
// Assumes pin inputs are synchronous to clk_sys; pins are split into
// input, output and output enable, resolved outside.
//
// What this block does
// - Low port feeds irq five only when latched high
// - Plain port is input only with latch one
// - Serial port bits map to fixed alternate functions
// - Analog pin feeds converter only when direction zero
// - Segment control one drives pin from display
// - Reset pin inputs reset and drives on faults
// - External slow clock enters input pin, output open
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_mux #(
  parameter int RST_CYCLES = pin_mux_pkg::RESET_DRIVE_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic lf_latch_wr,
  input wire logic [2:0] lf_latch_data,
  input wire logic lf_ext_clock_mode,
  input wire logic [2:0] lf_pin_in,
  output logic [2:0] lf_pin_out,
  output logic [2:0] lf_pin_oe,
  output logic [2:0] lf_port_read,
  output logic low_freq_osc_in,
  output logic ext_irq_five,
  output logic stop_release,
  input wire logic plain_latch_wr,
  input wire logic [6:0] plain_latch_data,
  input wire logic [6:0] plain_pin_in,
  output logic [6:0] plain_pin_out,
  output logic [6:0] plain_pin_oe,
  output logic [6:0] plain_port_read,
  input wire logic ser_latch_wr,
  input wire logic [7:0] ser_latch_data,
  input wire logic [7:0] serial_port_output_select,
  input wire logic ser2_data_out,
  input wire logic ser2_clock_out,
  input wire logic ser1_data_out,
  input wire logic ser1_clock_out,
  input wire logic pwm_divider_out,
  input wire logic [7:0] ser_pin_in,
  output logic [7:0] ser_pin_out,
  output logic [7:0] ser_pin_oe,
  output logic [7:0] ser_port_read,
  output logic ser2_data_in,
  output logic ser2_clock,
  output logic ser1_data_in,
  output logic ser1_clock,
  output logic ext_irq_three,
  output logic timer_three_input,
  input wire logic ana_latch_wr,
  input wire logic [7:0] ana_latch_data,
  input wire logic [7:0] analog_port_direction_ctrl,
  input wire logic [7:0] ana_pin_in,
  output logic [7:0] ana_pin_out,
  output logic [7:0] ana_pin_oe,
  output logic [7:0] ana_port_read,
  output logic [7:0] analog_in_enable,
  input wire logic seg_latch_wr,
  input wire logic [27:0] seg_latch_data,
  input wire logic [3:0] seg_output_ctrl,
  input wire logic [27:0] seg_drive,
  input wire logic [27:0] seg_pin_in,
  output logic [27:0] seg_pin_out,
  output logic [27:0] seg_pin_oe,
  output logic [27:0] seg_port_read,
  input wire logic wdt_reset_event,
  input wire logic trap_reset_event,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic ext_reset_req,
  input wire logic test_pin_in
);

  // ****************************************
  // Latch slices
  // ****************************************
  latch_port_if #(.W(pin_mux_pkg::LF_PORT_W)) lf_lp();
  latch_port_if #(.W(pin_mux_pkg::PLAIN_PORT_W)) pl_lp();
  latch_port_if #(.W(pin_mux_pkg::SER_PORT_W)) sr_lp();
  latch_port_if #(.W(pin_mux_pkg::SEG_PORT_W)) sg_lp();

  latch_port #(.W(pin_mux_pkg::LF_PORT_W),
    .RESET_VAL(pin_mux_pkg::LF_LATCH_RST)) u_lf
    (.clk_sys(clk_sys), .rst(rst), .lp(lf_lp.port));
  latch_port #(.W(pin_mux_pkg::PLAIN_PORT_W),
    .RESET_VAL(pin_mux_pkg::PLAIN_LATCH_RST)) u_pl
    (.clk_sys(clk_sys), .rst(rst), .lp(pl_lp.port));
  latch_port #(.W(pin_mux_pkg::SER_PORT_W),
    .RESET_VAL(pin_mux_pkg::SER_LATCH_RST)) u_sr
    (.clk_sys(clk_sys), .rst(rst), .lp(sr_lp.port));
  latch_port #(.W(pin_mux_pkg::SEG_PORT_W),
    .RESET_VAL(pin_mux_pkg::SEG_LATCH_RST)) u_sg
    (.clk_sys(clk_sys), .rst(rst), .lp(sg_lp.port));

  // Write strobes and alternate outputs feeding the slices.
  assign lf_lp.wr = lf_latch_wr;
  assign lf_lp.wdata = lf_latch_data;
  assign lf_lp.alt_sel = 3'h0;
  assign lf_lp.alt_val = 3'h0;
  assign pl_lp.wr = plain_latch_wr;
  assign pl_lp.wdata = plain_latch_data;
  assign pl_lp.alt_sel = 7'h00;
  assign pl_lp.alt_val = 7'h00;
  assign sr_lp.wr = ser_latch_wr;
  assign sr_lp.wdata = ser_latch_data;
  // Input-only bits offer a constant 1, so selecting them leaves the latch.
  assign sr_lp.alt_sel = serial_port_output_select;
  assign sr_lp.alt_val = {ser2_data_out, 1'b1, ser2_clock_out,
    ser1_data_out, 1'b1, ser1_clock_out, pwm_divider_out, 1'b1};
  assign sg_lp.wr = seg_latch_wr;
  assign sg_lp.wdata = seg_latch_data;
  assign sg_lp.alt_sel = 28'h0000000;
  assign sg_lp.alt_val = 28'h0000000;

  // ****************************************
  // Registered state
  // ****************************************
  typedef struct packed
  {
    logic [2:0] lf_out, lf_oe, lf_read;
    logic lf_clk, irq5, stop_rel;
    logic [6:0] pl_out, pl_oe, pl_read;
    logic [7:0] sr_out, sr_oe, sr_read;
    logic s2_di, s2_ck, s1_di, s1_ck, irq3;
    logic [7:0] an_latch, an_read, ain_en, an_oe;
    logic [27:0] sg_out, sg_oe, sg_read;
    pin_mux_pkg::rst_state_t rst_state;
    logic [pin_mux_pkg::RESET_CNT_W-1:0] rst_cnt;
    logic ext_rst, rst_oe;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [27:0] seg_sel;

  // Each segment control bit covers one group of eight pins; bit 3 covers only the last four.
  always_comb
  begin
    for (int i = 0; i < pin_mux_pkg::SEG_PORT_W; i++)
    begin
      seg_sel[i] = seg_output_ctrl[i / pin_mux_pkg::SEG_GROUP_W];
    end
  end

  // Pin logic: latch ports only ever sink, so a latch of 1 releases the
  // pin; this is what lets the same pin be read back as an input.
  always_comb
  begin
    state_next = state_reg;
    // Low-frequency port and its interrupt and stop-release inputs.
    state_next.lf_out = lf_lp.drive;
    state_next.lf_oe = ~lf_lp.drive;
    if (lf_ext_clock_mode)
    begin
      state_next.lf_oe[pin_mux_pkg::LF_IN_BIT] = 1'b0;
      state_next.lf_oe[pin_mux_pkg::LF_OUT_BIT] = 1'b0;
    end
    state_next.lf_read = lf_pin_in;
    state_next.lf_clk = lf_ext_clock_mode
      & lf_pin_in[pin_mux_pkg::LF_IN_BIT];
    state_next.irq5 = lf_pin_in[pin_mux_pkg::IRQ5_BIT]
      & lf_lp.latch[pin_mux_pkg::IRQ5_BIT];
    state_next.stop_rel = lf_pin_in[pin_mux_pkg::IRQ5_BIT]
      & lf_lp.latch[pin_mux_pkg::IRQ5_BIT];
    // Plain port: latch 1 leaves the pin undriven.
    state_next.pl_out = pl_lp.drive;
    state_next.pl_oe = ~pl_lp.drive;
    state_next.pl_read = plain_pin_in;
    // Serial port, gated alternate outputs and fixed input mapping.
    state_next.sr_out = sr_lp.drive;
    state_next.sr_oe = ~sr_lp.drive;
    state_next.sr_read = ser_pin_in;
    state_next.s2_di = ser_pin_in[pin_mux_pkg::SER2_DI_BIT];
    state_next.s2_ck = ser_pin_in[pin_mux_pkg::SER2_CK_BIT];
    state_next.s1_di = ser_pin_in[pin_mux_pkg::SER1_DI_BIT];
    state_next.s1_ck = ser_pin_in[pin_mux_pkg::SER1_CK_BIT];
    state_next.irq3 = ser_pin_in[pin_mux_pkg::IRQ3_BIT];
    // Analog port: a true tri-state port, one direction bit per pin.
    if (ana_latch_wr)
    begin
      state_next.an_latch = ana_latch_data;
    end
    state_next.an_read = ana_pin_in;
    state_next.ain_en = ~analog_port_direction_ctrl;
    // Kept as its own flop so the pin enable needs no output inverter.
    state_next.an_oe = analog_port_direction_ctrl;
    // Segment ports: display drive wins while the control bit is 1.
    for (int i = 0; i < pin_mux_pkg::SEG_PORT_W; i++)
    begin
      if (seg_sel[i])
      begin
        state_next.sg_out[i] = seg_drive[i];
        state_next.sg_oe[i] = 1'b1;
      end
      else
      begin
        state_next.sg_out[i] = sg_lp.drive[i];
        state_next.sg_oe[i] = ~sg_lp.drive[i];
      end
    end
    state_next.sg_read = seg_pin_in;
    // Reset pin: pull low for a fixed time after an internal fault.
    case (state_reg.rst_state)
      pin_mux_pkg::RST_IDLE:
      begin
        if (wdt_reset_event || trap_reset_event)
        begin
          state_next.rst_state = pin_mux_pkg::RST_DRIVE;
          state_next.rst_cnt =
            pin_mux_pkg::RESET_CNT_W'(RST_CYCLES - 1);
        end
      end
      pin_mux_pkg::RST_DRIVE:
      begin
        if (state_reg.rst_cnt == '0)
        begin
          state_next.rst_state = pin_mux_pkg::RST_IDLE;
        end
        else
        begin
          state_next.rst_cnt = state_reg.rst_cnt - 1'b1;
        end
      end
      default:
      begin
        state_next.rst_state = pin_mux_pkg::RST_IDLE;
      end
    endcase
    // Our own drive must not be mistaken for an external reset.
    state_next.ext_rst = ~reset_pin_in
      & (state_next.rst_state == pin_mux_pkg::RST_IDLE)
      & (state_reg.rst_state == pin_mux_pkg::RST_IDLE);
    // Registered from the next state, so it matches the state flop exactly.
    state_next.rst_oe = (state_next.rst_state == pin_mux_pkg::RST_DRIVE);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.lf_out <= pin_mux_pkg::LF_LATCH_RST;
      state_reg.pl_out <= pin_mux_pkg::PLAIN_LATCH_RST;
      state_reg.sr_out <= pin_mux_pkg::SER_LATCH_RST;
      state_reg.an_latch <= pin_mux_pkg::ANA_LATCH_RST;
      state_reg.ain_en <= 8'hFF;
      state_reg.sg_out <= pin_mux_pkg::SEG_LATCH_RST;
      state_reg.rst_state <= pin_mux_pkg::RST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs, all straight from state_reg
  // ****************************************
  assign lf_pin_out = state_reg.lf_out;
  assign lf_pin_oe = state_reg.lf_oe;
  assign lf_port_read = state_reg.lf_read;
  assign low_freq_osc_in = state_reg.lf_clk;
  assign ext_irq_five = state_reg.irq5;
  assign stop_release = state_reg.stop_rel;
  assign plain_pin_out = state_reg.pl_out;
  assign plain_pin_oe = state_reg.pl_oe;
  assign plain_port_read = state_reg.pl_read;
  assign ser_pin_out = state_reg.sr_out;
  assign ser_pin_oe = state_reg.sr_oe;
  assign ser_port_read = state_reg.sr_read;
  // Inputs reach peripherals regardless; software must clear select.
  assign ser2_data_in = state_reg.s2_di;
  assign ser2_clock = state_reg.s2_ck;
  assign ser1_data_in = state_reg.s1_di;
  assign ser1_clock = state_reg.s1_ck;
  assign ext_irq_three = state_reg.irq3;
  assign timer_three_input = state_reg.irq3;
  assign ana_pin_out = state_reg.an_latch;
  assign ana_pin_oe = state_reg.an_oe;
  assign ana_port_read = state_reg.an_read;
  assign analog_in_enable = state_reg.ain_en;
  assign seg_pin_out = state_reg.sg_out;
  assign seg_pin_oe = state_reg.sg_oe;
  assign seg_port_read = state_reg.sg_read;
  assign reset_pin_out = 1'b0 & state_reg.ext_rst;
  assign reset_pin_oe = state_reg.rst_oe;
  assign ext_reset_req = state_reg.ext_rst;
  // The test pin is never acted on; it is a factory input only.
  logic unused_test;
  assign unused_test = test_pin_in;

endmodule
`default_nettype wire

// file: verification/board_pin.sv
// Board side of one group of shared pins: pull-ups and optional sinks.
// Assumes out and oe come straight from the split pin outputs.
`timescale 1ns/1ps
`default_nettype none
module board_pin #(
  parameter int W = 8
)
(
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] ext_low,
  output logic [W-1:0] level
);
  // Wired AND: a released pin floats high unless the board sinks it.
  // A slow clock is fed by toggling ext_low on the input pin only.
  assign level = (~oe | out) & ~ext_low;
endmodule
`default_nettype wire

// file: verification/port_mux_sva.sv
// Port level checks for the pin function multiplexer.
// Assumes one clock domain with rst as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module port_mux_sva #(
  parameter int RST_CYCLES = 16
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] lf_pin_in,
  input wire logic lf_ext_clock_mode,
  input wire logic [2:0] lf_pin_oe,
  input wire logic low_freq_osc_in,
  input wire logic ext_irq_five,
  input wire logic stop_release,
  input wire logic [6:0] plain_pin_out,
  input wire logic [6:0] plain_pin_oe,
  input wire logic [7:0] serial_port_output_select,
  input wire logic ser2_data_out,
  input wire logic [7:0] ser_pin_in,
  input wire logic [7:0] ser_pin_out,
  input wire logic ser2_data_in,
  input wire logic [7:0] analog_port_direction_ctrl,
  input wire logic [7:0] analog_in_enable,
  input wire logic [7:0] ana_pin_oe,
  input wire logic [3:0] seg_output_ctrl,
  input wire logic [27:0] seg_drive,
  input wire logic [27:0] seg_pin_out,
  input wire logic [27:0] seg_pin_oe,
  input wire logic reset_pin_oe,
  input wire logic ext_reset_req
);
  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] run_cnt_reg;
  // Length of the current driven reset pulse, so no long repetition.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      run_cnt_reg <= 8'h00;
    else if (reset_pin_oe)
      run_cnt_reg <= run_cnt_reg + 8'h01;
    else
      run_cnt_reg <= 8'h00;
  end
  AST_IRQ5_GATE: assert property (!$past(rst) |-> ext_irq_five ==
    ($past(lf_pin_in[0]) && !lf_pin_oe[0]) && stop_release == ext_irq_five)
    else $error("irq five bad");
  AST_SLOW_CLK: assert property (!$past(rst) |-> low_freq_osc_in ==
    ($past(lf_pin_in[1]) && $past(lf_ext_clock_mode)))
    else $error("slow clock input bad");
  AST_SLOW_OPEN: assert property (!$past(rst) &&
    $past(lf_ext_clock_mode) |-> lf_pin_oe[2:1] == 2'h0)
    else $error("slow clock pins driven");
  AST_PLAIN_OD: assert property (plain_pin_oe == ~plain_pin_out)
    else $error("plain pin not open drain");
  AST_SER_MAP: assert property (!$past(rst) |->
    ser2_data_in == $past(ser_pin_in[6])) else $error("ser2 input bad");
  AST_SER_AND: assert property (!$past(rst) &&
    $past(serial_port_output_select[7]) && !$past(ser2_data_out)
    |-> !ser_pin_out[7]) else $error("ser2 output not gated");
  AST_ANA_DIR: assert property (!$past(rst) |->
    analog_in_enable == ~$past(analog_port_direction_ctrl) &&
    ana_pin_oe == ~analog_in_enable) else $error("analog direction bad");
  AST_SEG_SEL: assert property (!$past(rst) && $past(seg_output_ctrl[3])
    |-> seg_pin_oe[27:24] == 4'hF &&
    seg_pin_out[27:24] == $past(seg_drive[27:24]))
    else $error("segment drive bad");
  AST_RST_LEN: assert property ($fell(reset_pin_oe) |->
    run_cnt_reg == RST_CYCLES) else $error("reset pulse length bad");
  AST_RST_NOREQ: assert property ($past(reset_pin_oe) &&
    reset_pin_oe |-> !ext_reset_req) else $error("reset request while driving");
  cover property ($rose(reset_pin_oe));
  cover property (ext_irq_five);
  cover property (ext_reset_req);
  cover property ($past(seg_output_ctrl[3]) && seg_pin_oe[27]);
endmodule
bind port_pin_function_mux port_mux_sva #(.RST_CYCLES(RST_CYCLES)) sva_i (.*);
`default_nettype wire

// file: verification/port_pin_function_mux_tb.sv
// Self-checking bench for the port pin function multiplexer.
// Assumes the design, board_pin and port_mux_sva are compiled first.
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_mux_tb;
  logic clk_sys, rst, lf_latch_wr, lf_ext_clock_mode, low_freq_osc_in;
  logic ext_irq_five, stop_release, plain_latch_wr, ser_latch_wr;
  logic ser2_data_out, ser2_clock_out, ser1_data_out, ser1_clock_out;
  logic pwm_divider_out, ser2_data_in, ser2_clock, ser1_data_in, ser1_clock;
  logic ext_irq_three, timer_three_input, ana_latch_wr, seg_latch_wr;
  logic wdt_reset_event, trap_reset_event, reset_pin_in, reset_pin_out;
  logic reset_pin_oe, ext_reset_req, test_pin_in, rst_low;
  logic [2:0] lf_latch_data, lf_pin_in, lf_pin_out, lf_pin_oe, lf_port_read;
  logic [2:0] lf_low;
  logic [6:0] plain_latch_data, plain_pin_in, plain_pin_out, plain_pin_oe;
  logic [6:0] plain_port_read, pl_low;
  logic [7:0] ser_latch_data, serial_port_output_select, ser_pin_in, ser_low;
  logic [7:0] ser_pin_out, ser_pin_oe, ser_port_read, ana_latch_data;
  logic [7:0] analog_port_direction_ctrl, ana_pin_in, ana_pin_out, ana_pin_oe;
  logic [7:0] ana_port_read, analog_in_enable, ana_low;
  logic [27:0] seg_latch_data, seg_drive, seg_pin_in, seg_pin_out, seg_pin_oe;
  logic [27:0] seg_port_read, seg_low;
  logic [3:0] seg_output_ctrl;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  // ******************************
  // Design and board
  // ******************************
  port_pin_function_mux #(.RST_CYCLES(2)) DUT (.*);
  board_pin #(.W(3)) lf_b (.out(lf_pin_out), .oe(lf_pin_oe), .ext_low(lf_low),
    .level(lf_pin_in));
  board_pin #(.W(7)) pl_b (.out(plain_pin_out), .oe(plain_pin_oe),
    .ext_low(pl_low), .level(plain_pin_in));
  board_pin #(.W(8)) ser_b (.out(ser_pin_out), .oe(ser_pin_oe),
    .ext_low(ser_low), .level(ser_pin_in));
  board_pin #(.W(8)) ana_b (.out(ana_pin_out), .oe(ana_pin_oe),
    .ext_low(ana_low), .level(ana_pin_in));
  board_pin #(.W(28)) seg_b (.out(seg_pin_out), .oe(seg_pin_oe),
    .ext_low(seg_low), .level(seg_pin_in));
  board_pin #(.W(1)) rst_b (.out(reset_pin_out), .oe(reset_pin_oe),
    .ext_low(rst_low), .level(reset_pin_in));
  // Free-running 25 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Cuts a hung run short; the tests need well under 1000 cycles.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      results();
    end
  end
  // ******************************
  // Shared tasks
  // ******************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // Latch, pin and read-back latencies are fixed, so a fixed wait is fine.
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ******************************
  // Scenarios
  // ******************************
  // Every drive group starts on a rising edge, checks run at falling edges.
  task automatic t_low_port();
    @(posedge clk_sys);
    lf_low <= 3'h1;
    settle();
    chk(ext_irq_five, 1'h0);
    @(posedge clk_sys);
    lf_low <= 3'h0;
    settle();
    chk({ext_irq_five, stop_release}, 2'h3);
    @(posedge clk_sys);
    lf_latch_wr <= 1'h1;
    lf_latch_data <= 3'h0;
    @(posedge clk_sys);
    lf_latch_wr <= 1'h0;
    lf_ext_clock_mode <= 1'h1;
    settle();
    chk({ext_irq_five, stop_release, lf_pin_oe}, 5'h01);
    chk(low_freq_osc_in, 1'h1);
    @(posedge clk_sys);
    lf_low <= 3'h2;
    settle();
    chk(low_freq_osc_in, 1'h0);
    chk({lf_pin_out, lf_port_read}, 6'h04);
    @(posedge clk_sys);
    lf_ext_clock_mode <= 1'h0;
    lf_latch_wr <= 1'h1;
    lf_latch_data <= 3'h7;
    @(posedge clk_sys);
    lf_latch_wr <= 1'h0;
    settle();
    chk({ext_irq_five, stop_release, lf_pin_oe}, 5'h18);
    $display("low port test done");
  endtask
  task automatic t_plain();
    @(posedge clk_sys);
    plain_latch_wr <= 1'h1;
    plain_latch_data <= 7'h55;
    pl_low <= 7'h01;
    @(posedge clk_sys);
    plain_latch_wr <= 1'h0;
    settle();
    chk(plain_pin_oe, 7'h2A);
    chk(plain_pin_out, 7'h55);
    chk(plain_port_read, 7'h54);
    $display("plain port test done");
  endtask
  task automatic t_serial();
    @(posedge clk_sys);
    serial_port_output_select <= 8'hB6;
    ser2_clock_out <= 1'h1;
    ser1_clock_out <= 1'h1;
    settle();
    chk(ser_pin_oe, 8'h92);
    chk(ser_pin_out, 8'h6D);
    @(posedge clk_sys);
    {ser2_data_out, ser2_clock_out, ser1_data_out} <= 3'h5;
    {ser1_clock_out, pwm_divider_out} <= 2'h1;
    ser_latch_wr <= 1'h1;
    ser_latch_data <= 8'h7F;
    @(posedge clk_sys);
    ser_latch_wr <= 1'h0;
    settle();
    chk(ser_pin_oe, 8'hA4);
    @(posedge clk_sys);
    serial_port_output_select <= 8'h00;
    ser_latch_wr <= 1'h1;
    ser_latch_data <= 8'hFF;
    ser_low <= 8'h49;
    @(posedge clk_sys);
    ser_latch_wr <= 1'h0;
    settle();
    chk({ser2_data_in, ser2_clock, ser1_data_in, ser1_clock, ext_irq_three,
      timer_three_input}, 6'h14);
    @(posedge clk_sys);
    ser_low <= 8'h24;
    settle();
    chk({ser2_data_in, ser2_clock, ser1_data_in, ser1_clock, ext_irq_three,
      timer_three_input}, 6'h2B);
    chk(ser_port_read, 8'hDB);
    $display("serial port test done");
  endtask
  task automatic t_analog();
    @(posedge clk_sys);
    analog_port_direction_ctrl <= 8'h0F;
    ana_latch_wr <= 1'h1;
    ana_latch_data <= 8'hA5;
    ana_low <= 8'h30;
    @(posedge clk_sys);
    ana_latch_wr <= 1'h0;
    settle();
    chk(analog_in_enable, 8'hF0);
    chk({ana_pin_out, ana_pin_oe}, 16'hA50F);
    chk(ana_port_read, 8'hC5);
    $display("analog port test done");
  endtask
  task automatic t_segment();
    @(posedge clk_sys);
    seg_drive <= 28'h5A5A5A5;
    seg_output_ctrl <= 4'h9;
    settle();
    chk(seg_pin_oe, 28'hF0000FF);
    chk(seg_pin_out, 28'h5FFFFA5);
    @(posedge clk_sys);
    seg_output_ctrl <= 4'h0;
    seg_low <= 28'h0000F00;
    settle();
    chk(seg_port_read, 28'hFFFF0FF);
    @(posedge clk_sys);
    seg_latch_wr <= 1'h1;
    seg_latch_data <= 28'hFFF00FF;
    @(posedge clk_sys);
    seg_latch_wr <= 1'h0;
    settle();
    chk(seg_pin_oe, 28'h000FF00);
    chk(seg_port_read, 28'hFFF00FF);
    $display("segment port test done");
  endtask
  task automatic t_reset_pin(input logic trap);
    @(posedge clk_sys);
    wdt_reset_event <= ~trap;
    trap_reset_event <= trap;
    @(posedge clk_sys);
    wdt_reset_event <= 1'h0;
    trap_reset_event <= 1'h0;
    repeat (2)
    begin
      @(negedge clk_sys);
      chk({reset_pin_oe, reset_pin_out, reset_pin_in, ext_reset_req},
        4'h8);
    end
    @(negedge clk_sys);
    chk(reset_pin_oe, 1'h0);
    @(posedge clk_sys);
    rst_low <= 1'h1;
    settle();
    chk(ext_reset_req, 1'h1);
    @(posedge clk_sys);
    rst_low <= 1'h0;
    settle();
    $display("reset pin test done");
  endtask
  // Main sequence: inputs at time zero, reset, then the scenarios.
  initial
  begin
    rst = 1'h1;
    {lf_latch_wr, lf_ext_clock_mode, plain_latch_wr, ser_latch_wr} = 4'h0;
    {ser2_data_out, ser2_clock_out, ser1_data_out, ser1_clock_out} = 4'h0;
    {pwm_divider_out, ana_latch_wr, seg_latch_wr, rst_low} = 4'h0;
    {wdt_reset_event, trap_reset_event} = 2'h0;
    test_pin_in = 1'h0;
    {lf_latch_data, lf_low, pl_low, plain_latch_data} = 20'h0;
    {ser_latch_data, serial_port_output_select, ser_low} = 24'h0;
    {ana_latch_data, analog_port_direction_ctrl, ana_low} = 24'h0;
    {seg_latch_data, seg_drive, seg_low, seg_output_ctrl} = 88'h0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    @(negedge clk_sys);
    chk({plain_pin_oe, ser_pin_oe}, 15'h0000);
    chk(analog_in_enable, 8'hFF);
    t_low_port();
    t_plain();
    t_serial();
    t_analog();
    t_segment();
    t_reset_pin(1'h0);
    t_reset_pin(1'h1);
    results();
  end
endmodule
`default_nettype wire
